// file: vtam_pkg.sv
/*
  Constants for the valve travel alert monitor: travel scaling, setting
  ranges, drive extremes and timing.
  Assumes travel is carried as signed hundredths of a percent of ranged
  travel, so 100 % is 10000 counts.
*/
package vtam_pkg;
  // ------------------------------------------------------------
  // travel scaling and setting ranges
  // ------------------------------------------------------------
  localparam int TRV_W = 16;
  localparam logic signed [15:0] PCT_MIN = 16'shf63c; // -25 %
  localparam logic signed [15:0] PCT_MAX = 16'sh30d4; // 125 %
  localparam logic signed [15:0] DEV_MIN = 16'sh0000; // 0 %
  localparam logic signed [15:0] DEV_MAX = 16'sh2710; // 100 %
  localparam logic [31:0] FULL_SPAN = 32'h0000_2710;  // 100 % in counts
  localparam logic [5:0] DEV_T_MIN = 6'h01;           // seconds
  localparam logic [5:0] DEV_T_MAX = 6'h3c;           // seconds
  localparam logic [8:0] MOVE_T_MAX = 9'h190;         // seconds
  // ------------------------------------------------------------
  // drive extremes and alert layout (hi, lo, hi-hi, lo-lo)
  // ------------------------------------------------------------
  localparam logic signed [15:0] DRV_MAX = 16'sh7fff;
  localparam logic signed [15:0] DRV_MIN = 16'sh8000;
  localparam logic [3:0] ALERT_UP = 4'h5;             // bits 0,2 look upward
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 200000000;
  localparam int SAMPLE_HZ = 1000;                    // sample ticks a second
  localparam longint WDG_MS = 100;                    // watchdog time, ms
  localparam int WDG_CYC = int'(WDG_MS * CLK_HZ / 1000);
endpackage

// file: vtam_top.sv
/*
  Valve travel alert monitor: travel alerts, deviation alert, cutoffs,
  target limits, opening/closing rate limits and a watchdog.
  Assumes travel, target, tick, rearm and settings come from logic on
  core_clk; settings are held stable by the processor.
*/
// How it works
// R1 - an alert rises when travel passes above its high point or below its low point.
// R2 - a raised alert holds until travel is back past the point by the deadband.
// R3 - hi, lo, hi-hi and lo-lo alerts are four separate comparisons.
// R4 - the deadband setting is clamped to -25 % .. 125 %.
// R5 - each alert point setting is clamped to -25 % .. 125 %.
// R6 - beyond a cutoff the drive goes to max or min by cutoff side and zero polarity.
// R7 - beyond a cutoff the opening and closing rate limits are bypassed.
// R8 - deviation alert rises only after the deviation exceeds its point beyond the time.
// R9 - deviation alert holds until the deviation drops below its point.
// R10 - the deviation point is clamped to 0 % .. 100 %.
// R11 - the deviation time is clamped to 1 .. 60 seconds.
// R12 - the travel target is clamped between the low and high travel limits.
// R13 - the processor rearms the watchdog; a missed rearm resets the whole block.
// R14 - travel steps obey minimum opening and closing times of 0 .. 400 s, 0 meaning off.
// R15 - alert comparisons and the deviation timer advance once a sample tick and alerts clear at reset.
`timescale 1ns/1ps
module vtam_top import vtam_pkg::*; #(
  parameter int SAMPLE_RATE = SAMPLE_HZ,
  parameter int WDG_CYCLES = WDG_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // sampled travel
  input wire logic sample_tick,
  input wire logic signed [15:0] travel,
  input wire logic signed [15:0] target,
  // alert settings
  input wire logic signed [15:0] pt_hi,
  input wire logic signed [15:0] pt_lo,
  input wire logic signed [15:0] pt_hh,
  input wire logic signed [15:0] pt_ll,
  input wire logic signed [15:0] alert_db,
  input wire logic signed [15:0] dev_pt,
  input wire logic [5:0] dev_time_s,
  // cutoffs, limits, rates
  input wire logic signed [15:0] cut_hi,
  input wire logic signed [15:0] cut_lo,
  input wire logic signed [15:0] lim_hi,
  input wire logic signed [15:0] lim_lo,
  input wire logic [8:0] open_time_s,
  input wire logic [8:0] close_time_s,
  input wire logic zero_closes,
  // watchdog
  input wire logic wdg_rearm,
  // results
  output logic alert_hi,
  output logic alert_lo,
  output logic alert_hh,
  output logic alert_ll,
  output logic dev_alert,
  output logic cut_active,
  output logic signed [15:0] drive,
  output logic wdg_reset
);
  initial begin
    if (SAMPLE_RATE < 1 || SAMPLE_RATE > 100000 || WDG_CYCLES < 2) begin
      $error("vtam_top: unsupported parameter value");
    end
  end

  // ------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] alert;
    logic dev;
    logic [31:0] dev_cnt;
    logic signed [15:0] sp;
    logic [31:0] acc;
    logic [31:0] wdg;
    logic cut_hi;
    logic cut_lo;
    logic cut;
    logic signed [15:0] drive;
    logic wdg_rst;
  } vtam_state_s;

  localparam vtam_state_s ST_RST = '0;

  function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
      input logic signed [15:0] lo, input logic signed [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic rst_m_r;
  logic rst_sync_n;
  vtam_state_s s_r;
  vtam_state_s s_nxt;

  // ------------------------------------------------------------
  // clamped settings
  // ------------------------------------------------------------
  logic signed [15:0] pt_c [4];
  logic signed [17:0] db_x;
  logic signed [15:0] dpt_c;
  logic [5:0] dt_c;
  logic signed [15:0] lim_hi_c;
  logic signed [15:0] lim_lo_c;
  logic signed [15:0] tgt_c;
  logic [31:0] dev_lim;
  logic [31:0] per_open;
  logic [31:0] per_close;
  logic signed [17:0] tr_x;
  logic signed [17:0] diff;
  logic [17:0] adiff;
  logic wdg_exp;

  // settings outside their range are pinned to the nearest legal value
  always_comb begin
    pt_c[0] = clamp16(pt_hi, PCT_MIN, PCT_MAX); // R5
    pt_c[1] = clamp16(pt_lo, PCT_MIN, PCT_MAX);
    pt_c[2] = clamp16(pt_hh, PCT_MIN, PCT_MAX);
    pt_c[3] = clamp16(pt_ll, PCT_MIN, PCT_MAX);
    db_x = 18'(clamp16(alert_db, PCT_MIN, PCT_MAX)); // R4
    dpt_c = clamp16(dev_pt, DEV_MIN, DEV_MAX); // R10
    dt_c = (dev_time_s < DEV_T_MIN) ? DEV_T_MIN : // R11
           ((dev_time_s > DEV_T_MAX) ? DEV_T_MAX : dev_time_s);
    lim_hi_c = clamp16(lim_hi, PCT_MIN, PCT_MAX);
    lim_lo_c = clamp16(lim_lo, PCT_MIN, PCT_MAX);
    tgt_c = clamp16(target, lim_lo_c, lim_hi_c); // R12
    dev_lim = 32'(dt_c) * 32'(SAMPLE_RATE);
    per_open = 32'((open_time_s > MOVE_T_MAX) ? MOVE_T_MAX : open_time_s) // R14
               * 32'(SAMPLE_RATE);
    per_close = 32'((close_time_s > MOVE_T_MAX) ? MOVE_T_MAX : close_time_s)
                * 32'(SAMPLE_RATE);
    tr_x = 18'(travel);
    diff = 18'(tgt_c) - tr_x;
    adiff = diff[17] ? 18'(-diff) : 18'(diff);
    wdg_exp = (s_r.wdg == 32'(WDG_CYCLES - 1)); // R13
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // everything except the rate stepper, drive and watchdog waits for a sample tick
  always_comb begin
    logic signed [17:0] p;
    logic set;
    logic clr;
    s_nxt = s_r;
    p = '0;
    set = 1'b0;
    clr = 1'b0;
    s_nxt.wdg_rst = 1'b0;
    if (sample_tick) begin // R15
      for (int i = 0; i < 4; i++) begin // R3
        p = 18'(pt_c[i]);
        if (ALERT_UP[i]) begin
          set = tr_x > p; // R1
          clr = tr_x <= p - db_x; // R2
        end else begin
          set = tr_x < p;
          clr = tr_x >= p + db_x;
        end
        s_nxt.alert[i] = s_r.alert[i] ? !clr : set;
      end
      // continuity is broken as soon as the deviation stops exceeding
      if (adiff > 18'(dpt_c)) begin
        if (s_r.dev_cnt >= dev_lim) begin
          s_nxt.dev = 1'b1; // R8
        end else begin
          s_nxt.dev_cnt = s_r.dev_cnt + 32'h1;
        end
      end else begin
        s_nxt.dev_cnt = '0;
        if (adiff < 18'(dpt_c)) begin
          s_nxt.dev = 1'b0; // R9
        end
      end
      s_nxt.cut_hi = travel > clamp16(cut_hi, PCT_MIN, PCT_MAX);
      s_nxt.cut_lo = travel < clamp16(cut_lo, PCT_MIN, PCT_MAX);
      s_nxt.cut = s_nxt.cut_hi | s_nxt.cut_lo; // R6
    end
    // rate stepper: one count per cycle, credit of full span per tick
    if (s_r.cut_hi || s_r.cut_lo) begin
      s_nxt.sp = tgt_c; // R7
      s_nxt.acc = '0;
    end else if (tgt_c > s_r.sp) begin
      if (per_open == 32'h0) begin
        s_nxt.sp = tgt_c; // R14
        s_nxt.acc = '0;
      end else begin
        s_nxt.acc = s_r.acc + (sample_tick ? FULL_SPAN : 32'h0);
        if (s_nxt.acc >= per_open) begin
          s_nxt.acc = s_nxt.acc - per_open; // R14
          s_nxt.sp = s_r.sp + 16'sh0001;
        end
      end
    end else if (tgt_c < s_r.sp) begin
      if (per_close == 32'h0) begin
        s_nxt.sp = tgt_c;
        s_nxt.acc = '0;
      end else begin
        s_nxt.acc = s_r.acc + (sample_tick ? FULL_SPAN : 32'h0);
        if (s_nxt.acc >= per_close) begin
          s_nxt.acc = s_nxt.acc - per_close; // R14
          s_nxt.sp = s_r.sp - 16'sh0001;
        end
      end
    end else begin
      s_nxt.acc = '0;
    end
    // drive follows the cutoff flags as they stand this cycle
    if (s_r.cut_hi) begin
      s_nxt.drive = zero_closes ? DRV_MAX : DRV_MIN; // R6
    end else if (s_r.cut_lo) begin
      s_nxt.drive = zero_closes ? DRV_MIN : DRV_MAX; // R6
    end else begin
      s_nxt.drive = s_nxt.sp;
    end
    // a missed rearm throws away all state, like a power-up
    s_nxt.wdg = wdg_rearm ? 32'h0 : s_r.wdg + 32'h1;
    if (wdg_exp) begin
      s_nxt = ST_RST; // R13
      s_nxt.wdg_rst = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // reset release is synchronised so no flop leaves reset mid-edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_sync_n <= rst_m_r;
    end
  end

  // all alerts clear at reset
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_r <= ST_RST; // R15
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign alert_hi = s_r.alert[0];
  assign alert_lo = s_r.alert[1];
  assign alert_hh = s_r.alert[2];
  assign alert_ll = s_r.alert[3];
  assign dev_alert = s_r.dev;
  assign cut_active = s_r.cut;
  assign drive = s_r.drive;
  assign wdg_reset = s_r.wdg_rst;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_hi_set;
    @(posedge core_clk) disable iff (!rst_sync_n)
    // a negative deadband may drop a raised alert while still above its point
    (sample_tick && !wdg_exp && tr_x > 18'(pt_c[0]) &&
     (!alert_hi || tr_x > 18'(pt_c[0]) - db_x)) |=> alert_hi;
  endproperty
  a_hi_set: assert property (p_hi_set) else $error("high alert missed"); // R1

  property p_lo_hold;
    @(posedge core_clk) disable iff (!rst_sync_n)
    (alert_lo && sample_tick && !wdg_exp && tr_x < 18'(pt_c[1]) + db_x) |=> alert_lo;
  endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("low alert dropped early"); // R2

  property p_ll_set;
    @(posedge core_clk) disable iff (!rst_sync_n)
    (sample_tick && !wdg_exp && tr_x < 18'(pt_c[3]) &&
     (!alert_ll || tr_x < 18'(pt_c[3]) + db_x)) |=> alert_ll;
  endproperty
  a_ll_set: assert property (p_ll_set) else $error("low-low alert missed"); // R3

  property p_cut_drive;
    @(posedge core_clk) disable iff (!rst_sync_n)
    (s_r.cut_hi && zero_closes && !wdg_exp) |=> drive == DRV_MAX;
  endproperty
  a_cut_drive: assert property (p_cut_drive) else $error("cutoff drive wrong"); // R6

  property p_cut_norate;
    @(posedge core_clk) disable iff (!rst_sync_n)
    (cut_active && !wdg_exp) |=> s_r.sp == $past(tgt_c);
  endproperty
  a_cut_norate: assert property (p_cut_norate) else $error("rate limit in cutoff"); // R7

  property p_dev_rise;
    @(posedge core_clk) disable iff (!rst_sync_n)
    $rose(dev_alert) |-> $past(s_r.dev_cnt) >= $past(dev_lim);
  endproperty
  a_dev_rise: assert property (p_dev_rise) else $error("deviation alert early"); // R8

  property p_dev_clear;
    @(posedge core_clk) disable iff (!rst_sync_n)
    (dev_alert && sample_tick && adiff < 18'(dpt_c)) |=> !dev_alert;
  endproperty
  a_dev_clear: assert property (p_dev_clear) else $error("deviation alert stuck"); // R9

  property p_tgt_clamp;
    @(posedge core_clk) disable iff (!rst_sync_n)
    (lim_lo_c <= lim_hi_c) |-> (tgt_c >= lim_lo_c && tgt_c <= lim_hi_c);
  endproperty
  a_tgt_clamp: assert property (p_tgt_clamp) else $error("target outside limits"); // R12

  property p_wdg;
    @(posedge core_clk) disable iff (!rst_sync_n)
    wdg_exp |=> (wdg_reset && !alert_hi && !alert_lo && !alert_hh && !alert_ll && !dev_alert);
  endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog reset missing"); // R13
endmodule

// file: vtam_valve_model.sv
/*
  Behavioural valve actuator with travel sensor, standing beyond the drive.
  Assumes the bench asks for a stem position; the sensor reports it LAG cycles later.
*/
`timescale 1ns/1ps
module vtam_valve_model import vtam_pkg::*; #(
  parameter int LAG = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // drive and wanted stem position
  input wire logic signed [15:0] drive,
  input wire logic signed [15:0] pos_cmd,
  // sensed travel and stop flag
  output logic signed [15:0] travel,
  output logic pinned
);
  logic signed [15:0] pipe_r [0:LAG-1];
  // sensor lag: stem settles only after LAG edges, never at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LAG; i++) pipe_r[i] <= '0;
    end else begin
      pipe_r[0] <= pos_cmd;
      for (int i = 1; i < LAG; i++) pipe_r[i] <= pipe_r[i-1];
    end
  end
  assign travel = pipe_r[LAG-1];
  // extreme drive pins the stem on a stop; flagged only
  assign pinned = (drive == DRV_MAX) || (drive == DRV_MIN);
endmodule

// file: vtam_top_tb.sv
/*
  Self-checking bench for the travel alert monitor with a valve model.
  Assumes short watchdog and sample-rate parameters; expectations come from a tick model.
*/
`timescale 1ns/1ps
module vtam_top_tb import vtam_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_tick = 1'b0;
  logic signed [15:0] target, pos_cmd, alert_db, dev_pt, cut_hi, cut_lo, lim_hi, lim_lo;
  logic signed [15:0] drive, travel;
  logic signed [15:0] pts [0:3];
  logic [5:0] dev_time_s;
  logic [8:0] open_time_s, close_time_s;
  logic zero_closes, wdg_rearm, dev_alert, cut_active, wdg_reset;
  logic al [0:3];
  bit ea [0:3];
  bit ed;
  int dcnt, error_cnt = 0, num_checks = 0;
  localparam int SRATE = 2;   // short sample rate keeps persistence tests small
  localparam int WDG_T = 200; // short watchdog time

  always #2.5 core_clk = ~core_clk;

  vtam_top #(.SAMPLE_RATE(SRATE), .WDG_CYCLES(WDG_T)) vtam_top_inst (.core_clk(core_clk),
    .rst_n(rst_n), .sample_tick(sample_tick), .travel(travel), .target(target),
    .pt_hi(pts[0]), .pt_lo(pts[1]), .pt_hh(pts[2]), .pt_ll(pts[3]), .alert_db(alert_db),
    .dev_pt(dev_pt), .dev_time_s(dev_time_s), .cut_hi(cut_hi), .cut_lo(cut_lo),
    .lim_hi(lim_hi), .lim_lo(lim_lo), .open_time_s(open_time_s),
    .close_time_s(close_time_s), .zero_closes(zero_closes), .wdg_rearm(wdg_rearm),
    .alert_hi(al[0]), .alert_lo(al[1]), .alert_hh(al[2]), .alert_ll(al[3]),
    .dev_alert(dev_alert), .cut_active(cut_active), .drive(drive), .wdg_reset(wdg_reset));
  vtam_valve_model #(.LAG(1)) vtam_valve_model_inst (.core_clk(core_clk), .rst_n(rst_n),
    .drive(drive), .pos_cmd(pos_cmd), .travel(travel), .pinned());

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function int clp(int v, int lo, int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one sample tick, then model update and compare; gap spaces ticks for the stepper
  task tick(input int gap = 0);
    int p, d, df;
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    #1 sample_tick = 1'b1;
    @(posedge core_clk);
    #1 sample_tick = 1'b0;
    @(posedge core_clk);
    #1;
    d = clp(alert_db, -2500, 12500);
    for (int i = 0; i < 4; i++) begin
      p = clp(pts[i], -2500, 12500);
      if (ALERT_UP[i]) ea[i] = ea[i] ? (pos_cmd > p - d) : (pos_cmd > p);
      else ea[i] = ea[i] ? (pos_cmd < p + d) : (pos_cmd < p);
      chk("alert", 16'(al[i]), 16'(ea[i]));
    end
    df = clp(target, clp(lim_lo, -2500, 12500), clp(lim_hi, -2500, 12500)) - pos_cmd;
    df = df < 0 ? -df : df;
    p = clp(dev_pt, 0, 10000);
    dcnt = df > p ? dcnt + 1 : 0;
    if (df < p) ed = 0;
    if (dcnt > clp(dev_time_s, 1, 60) * SRATE) ed = 1;
    chk("dev_alert", 16'(dev_alert), 16'(ed));
    d = pos_cmd > clp(cut_hi, -2500, 12500) || pos_cmd < clp(cut_lo, -2500, 12500);
    chk("cut_active", 16'(cut_active), 16'(d));
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hbf38));
    {target, pos_cmd, alert_db, dev_pt} = '0;
    pts = '{16'sd9000, 16'sd1000, 16'sd9900, 16'sd100};
    {cut_hi, cut_lo, lim_hi, lim_lo} = {16'sh7fff, 16'sh8000, 16'sh7fff, 16'sh8000};
    {dev_time_s, open_time_s, close_time_s, zero_closes} = '0;
    wdg_rearm = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk("reset_out", 16'({al[0], al[1], al[2], al[3], dev_alert, cut_active, wdg_reset}),
        16'h0000);
    chk("reset_drive", drive, 16'h0000);
    repeat (2) @(posedge core_clk);
    // random sweeps; last phase takes out-of-range deadband and point
    for (int ph = 0; ph < 4; ph++) begin
      dev_time_s = 6'($urandom_range(0, 2));
      alert_db = ph == 3 ? 16'sd20000 : 16'($urandom_range(0, 3000)) - 16'sd200;
      dev_pt = 16'($urandom_range(0, 11000)) - 16'sd500;
      for (int i = 0; i < 4; i++) pts[i] = 16'($urandom_range(0, 16000)) - 16'sd3000;
      if (ph == 3) pts[2] = 16'sh7fff;
      repeat (150) begin
        if ($urandom_range(0, 3) == 0) pos_cmd = 16'($urandom_range(0, 15000)) - 16'sd2500;
        if ($urandom_range(0, 7) == 0) target = 16'($urandom_range(0, 15000)) - 16'sd2500;
        tick();
      end
      $display("test random phase %0d done", ph);
    end
    // longest persistence: time setting above 60 s
    {dev_time_s, dev_pt, target, pos_cmd} = {6'h3f, 16'sd500, 16'sd0, 16'sd0};
    tick();
    target = 16'sd10000;
    repeat (123) tick();
    pos_cmd = 16'sd10000;
    tick();
    $display("test deviation time done");
    // cutoffs with slow rate limits, both sides and polarities
    {dev_pt, cut_hi, cut_lo, target} = {16'sd10000, 16'sd9000, 16'sd1000, 16'sd5000};
    {open_time_s, close_time_s} = {9'd400, 9'd400};
    for (int z = 0; z < 2; z++) begin
      for (int s = 0; s < 2; s++) begin
        zero_closes = z[0];
        pos_cmd = s ? 16'sd9500 : 16'sd500;
        tick(15);
        @(posedge core_clk);
        #1 chk("drive_cut", drive, (s == z) ? DRV_MAX : DRV_MIN);
        pos_cmd = 16'sd5000;
        tick(15);
        @(posedge core_clk);
        #1 chk("drive_after_cut", drive, 16'sd5000);
      end
    end
    $display("test cutoff done");
    // target clamp with rate limits off
    {open_time_s, close_time_s, cut_hi, cut_lo} = {9'd0, 9'd0, 16'sh7fff, 16'sh8000};
    {lim_hi, lim_lo, target} = {16'sd8000, 16'sd2000, 16'sd9000};
    tick();
    repeat (2) @(posedge core_clk);
    #1 chk("drive_lim_hi", drive, 16'sd8000);
    target = 16'sd500;
    tick();
    repeat (2) @(posedge core_clk);
    #1 chk("drive_lim_lo", drive, 16'sd2000);
    $display("test limits done");
    // one-second opening time: one tick moves half the span, closing is free
    {lim_hi, lim_lo, open_time_s, target} = {16'sh7fff, 16'sh8000, 9'd1, 16'sd0};
    tick();
    target = 16'sd10000;
    tick();
    repeat (5100) @(posedge core_clk);
    #1 chk("drive_rate", drive, 16'sd5000);
    // one-second closing time: half the span down in 5000 cycles
    {close_time_s, target} = {9'd1, 16'sd0};
    tick();
    repeat (2498) @(posedge core_clk);
    #1 chk("drive_close_mid", drive, 16'sd2500);
    repeat (2600) @(posedge core_clk);
    #1 chk("drive_close", drive, 16'sd0);
    $display("test rate done");
    // missed rearm resets the block, alert included
    {pos_cmd, pts[0]} = {16'sd9000, 16'sd1000};
    tick();
    wdg_rearm = 1'b0;
    dcnt = 0;
    while (wdg_reset !== 1'b1 && dcnt < 400) begin
      @(posedge core_clk);
      #1 dcnt++;
    end
    chk("wdg_time", 16'(dcnt), 16'(WDG_T));
    chk("wdg_clear", 16'({al[0], al[1], al[2], al[3], dev_alert, cut_active}),
        16'h0000);
    @(posedge core_clk);
    #1 chk("wdg_pulse", 16'(wdg_reset), 16'h0000);
    wdg_rearm = 1'b1;
    $display("test watchdog done");
    stop_test;
  end
endmodule
